// ===== common/sdhdp_defs.svh
// Offsets, field positions, reset values and sizes of the card data port and interrupt enables.
`ifndef SDHDP_DEFS_SVH
`define SDHDP_DEFS_SVH
`define SDHDP_DATA_OFS        32'h5a00003c
`define SDHDP_DATA_BE_BYTE_OFS 32'h5a00003f
`define SDHDP_IRQEN_OFS       32'h5a000040
`define SDHDP_FLAGS_OFS       32'h5a000044
`define SDHDP_FIFOSTAT_OFS    32'h5a000048
`define SDHDP_CTRL_OFS        32'h5a00004c
`define SDHDP_DATA_RST        32'h00000000
`define SDHDP_IRQEN_RST       18'h00000
`define SDHDP_IRQEN_W         18
`define SDHDP_EV_RSP_CRC      17
`define SDHDP_EV_CMD_SENT     16
`define SDHDP_EV_CMD_TOUT     15
`define SDHDP_EV_RSP_END      14
`define SDHDP_EV_RWAIT        13
`define SDHDP_EV_IO_IRQ       12
`define SDHDP_EV_FIFO_FAIL    11
`define SDHDP_EV_CRC_STA      10
`define SDHDP_EV_DAT_CRC      9
`define SDHDP_EV_DAT_TOUT     8
`define SDHDP_EV_DAT_FIN      7
`define SDHDP_EV_BUSY_FIN     6
`define SDHDP_EV_SBIT_ERR     5
`define SDHDP_EV_TX_HALF      4
`define SDHDP_EV_TX_EMPTY     3
`define SDHDP_EV_RX_LAST      2
`define SDHDP_EV_RX_FULL      1
`define SDHDP_EV_RX_HALF      0
`define SDHDP_LATCH_MASK      18'h3ffe0
`define SDHDP_FIFO_BYTES      64
`define SDHDP_TX_HALF_LVL     32
`define SDHDP_RX_HALF_LVL     32
`endif

// ===== common/sdhdp_pkg.sv
// Types shared by the card data port block.
package sdhdp_pkg;
  typedef enum logic [1:0] {
    SDHDP_IDLE = 2'b00,
    SDHDP_ACK  = 2'b01,
    SDHDP_REST = 2'b11
  } sdhdp_bus_st_t;
  typedef enum logic {
    SDHDP_LITTLE = 1'b0,
    SDHDP_BIG    = 1'b1
  } sdhdp_endian_t;
endpackage

// ===== hdl/sdhdp_event_flags.sv
// Sticky event flags with write-one-to-clear and level status inputs.
`timescale 1ns/1ps
`include "sdhdp_defs.svh"
module sdhdp_event_flags #(
  parameter int W = 18
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] event_i,
  input  wire logic [W-1:0] latch_mask_i,
  input  wire logic [W-1:0] clear_i,
  output logic      [W-1:0] flags_o
);
  logic [W-1:0] sticky_r;

  // A set in the same cycle as a clear wins so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_r <= '0;
    end else begin
      sticky_r <= ((sticky_r & ~clear_i) | event_i) & latch_mask_i;
    end
  end

  // Unlatched bits show the live level of the condition.
  assign flags_o = sticky_r | (event_i & ~latch_mask_i);

  a_set_beats_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(event_i & latch_mask_i)) |=> (|sticky_r))
    else $error("latched event lost");
  a_hold_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (sticky_r[W-1] && !clear_i[W-1]) |=> sticky_r[W-1])
    else $error("flag dropped without clear");
endmodule

// ===== hdl/sdhdp_tx_fifo.sv
// Byte FIFO for outgoing card data with occupancy count and level flags.
`timescale 1ns/1ps
`include "sdhdp_defs.svh"
module sdhdp_tx_fifo #(
  parameter int DEPTH = `SDHDP_FIFO_BYTES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  output logic            wr_ready_o,
  input  wire logic       rd_i,
  output logic [7:0]      rd_data_o,
  output logic            rd_valid_o,
  output logic [6:0]      count_o,
  output logic            half_o,
  output logic            empty_o
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]    mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [6:0]    cnt_r;
  logic          do_wr;
  logic          do_rd;

  initial begin
    if (DEPTH != 64) $error("fifo depth must be 64");
  end

  assign do_wr = wr_i && (cnt_r != 7'(DEPTH));
  assign do_rd = rd_i && (cnt_r != 7'h00);

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_r[wp_r] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= 7'h00;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + 7'(do_wr) - 7'(do_rd);
    end
  end

  assign rd_data_o  = mem_r[rp_r];
  assign rd_valid_o = (cnt_r != 7'h00);
  assign wr_ready_o = (cnt_r != 7'(DEPTH));
  assign count_o    = cnt_r;
  assign half_o     = (cnt_r <= 7'(`SDHDP_TX_HALF_LVL));
  assign empty_o    = (cnt_r == 7'h00);

  a_count_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_r <= 7'(DEPTH))
    else $error("fifo count above depth");
  a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_wr && !do_rd) |=> (cnt_r == $past(cnt_r) + 7'h01))
    else $error("fifo count did not step");
endmodule

// ===== hdl/sdhdp_top.sv
// Card data window, interrupt enables and interrupt request of the card host.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "sdhdp_defs.svh"

// Contract
// - Data window is 32 bits, resets zero
// - Little endian: word and byte access allowed
// - Big endian: word at base, byte separate
// - Bit 17 gates response CRC failure
// - Bit 16 gates command sent, no response
// - Bit 15 gates command response timeout
// - Bit 14 gates command response received
// - Bit 13 gates read wait request
// - Bit 12 gates card IO interrupt
// - Bit 11 gates FIFO failure
// - Bit 10 gates write CRC status failure
// - Bits 9, 8 gate data CRC, timeout
// - Bit 7 gates transfer finished
// - Bit 6 gates busy check done
// - Bit 5 gates missing start bit
// - Bit 4 gates transmit FIFO half
// - Bit 3 gates transmit FIFO empty
// - Bit 2 gates receive FIFO final data
// - Bit 1 gates receive FIFO full
// - Bit 0 gates receive FIFO half
// - All enables reset to zero
// - Latched flags clear by writing one
// - Transmit FIFO 64 bytes, half, empty, count
module sdhdp_top #(
  parameter int FIFO_BYTES = `SDHDP_FIFO_BYTES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire sdhdp_pkg::sdhdp_endian_t endian_i,
  input  wire logic [17:0]           host_event_i,
  input  wire logic [7:0]            rx_byte_i,
  input  wire logic                  rx_byte_valid_i,
  output logic                       rx_byte_ready_o,
  input  wire logic                  tx_byte_take_i,
  output logic      [7:0]            tx_byte_o,
  output logic                       tx_byte_valid_o,
  output logic      [6:0]            fifo_byte_count_o,
  output logic                       irq_o
);
  import sdhdp_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  sdhdp_bus_st_t bus_st_r;
  sdhdp_endian_t endian_r;
  logic [31:0] card_data_window_r;
  logic [17:0] host_event_irq_enable_r;
  logic [17:0] flag_clear_r;
  logic [17:0] flags;
  logic [17:0] raw_events;
  logic [31:0] rd_data_nxt;
  logic [31:0] wb_dat_r;
  logic        irq_r;
  logic [6:0]  fifo_byte_count_r;
  logic        tx_push_r;
  logic [7:0]  tx_push_data_r;
  logic [1:0]  tx_bytes_left_r;
  logic [31:0] tx_word_r;
  logic        tx_full_r;
  logic        tx_ready;
  logic        tx_half;
  logic        tx_empty;
  logic [6:0]  tx_count;
  logic [7:0]  tx_head;
  logic        tx_head_valid;
  logic        rx_valid_r;
  logic        rx_last_r;
  logic        req;
  logic        wr_data;
  logic        wr_data_byte;
  logic        rd_data;
  logic        rd_data_byte;

  initial begin
    if (FIFO_BYTES != 64) $error("only a 64 byte fifo is supported");
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic is_data_word(input logic [31:0] a, input logic [3:0] s);
    is_data_word = (a == `SDHDP_DATA_OFS) && (s == 4'hf);
  endfunction

  // Byte access position depends on the current endian mode.
  function automatic logic is_data_byte(input logic [31:0] a, input logic [3:0] s,
                                        input sdhdp_endian_t e);
    if (e == SDHDP_LITTLE) begin
      is_data_byte = (a == `SDHDP_DATA_OFS) && (s == 4'h1);
    end else begin
      is_data_byte = (a == `SDHDP_DATA_BE_BYTE_OFS) && (s == 4'h8);
    end
  endfunction

  assign req          = wb_cyc_i && wb_stb_i && (bus_st_r == SDHDP_IDLE);
  assign wr_data      = req && wb_we_i && is_data_word(wb_adr_i, wb_sel_i);
  assign wr_data_byte = req && wb_we_i && is_data_byte(wb_adr_i, wb_sel_i, endian_r);
  assign rd_data      = req && !wb_we_i && is_data_word(wb_adr_i, wb_sel_i);
  assign rd_data_byte = req && !wb_we_i && is_data_byte(wb_adr_i, wb_sel_i, endian_r);

  // Endian mode is sampled only between accesses so a transfer never changes form.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      endian_r <= SDHDP_LITTLE;
    end else if (bus_st_r == SDHDP_IDLE && !(wb_cyc_i && wb_stb_i)) begin
      endian_r <= endian_i;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone handshake: one wait state, then a rest cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st_r <= SDHDP_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      case (bus_st_r)
        SDHDP_IDLE: begin
          if (req) begin
            bus_st_r <= SDHDP_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        SDHDP_ACK: begin
          bus_st_r <= SDHDP_REST;
          wb_ack_o <= 1'b0;
        end
        default: begin
          bus_st_r <= SDHDP_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read mux; unmapped addresses read as zero
  // ----------------------------------------------------------------------
  always_comb begin
    rd_data_nxt = 32'h00000000;
    if (endian_r == SDHDP_BIG && is_data_byte(wb_adr_i, wb_sel_i, endian_r)) begin
      rd_data_nxt = {card_data_window_r[7:0], 24'h000000};
    end else if (wb_adr_i == `SDHDP_DATA_OFS) begin
      rd_data_nxt = card_data_window_r;
    end else if (wb_adr_i == `SDHDP_IRQEN_OFS) begin
      rd_data_nxt = {14'h0000, host_event_irq_enable_r};
    end else if (wb_adr_i == `SDHDP_FLAGS_OFS) begin
      rd_data_nxt = {14'h0000, flags};
    end else if (wb_adr_i == `SDHDP_FIFOSTAT_OFS) begin
      rd_data_nxt = {22'h000000, rx_valid_r, tx_half, fifo_byte_count_r, 1'b0};
    end else if (wb_adr_i == `SDHDP_CTRL_OFS) begin
      rd_data_nxt = {31'h00000000, endian_r};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_r <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      wb_dat_r <= rd_data_nxt;
    end
  end
  assign wb_dat_o = wb_dat_r;

  // ----------------------------------------------------------------------
  // Data window: writes feed the transmit FIFO, reads pop received data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_data_window_r <= `SDHDP_DATA_RST;
    end else if (wr_data) begin
      card_data_window_r <= wb_dat_i;
    end else if (wr_data_byte) begin
      card_data_window_r <= (endian_r == SDHDP_LITTLE) ?
                            {24'h000000, wb_dat_i[7:0]} : {24'h000000, wb_dat_i[31:24]};
    end else if (rx_valid_r == 1'b0 && rx_byte_valid_i) begin
      card_data_window_r <= {card_data_window_r[23:0], rx_byte_i};
    end
  end

  // Received bytes are taken one at a time while the window is free for reading.
  // A byte taken in the cycle of a window read must stay marked, or it is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_r      <= 1'b0;
      rx_byte_ready_o <= 1'b1;
      rx_last_r       <= 1'b0;
    end else if (rx_byte_valid_i && !rx_valid_r) begin
      rx_valid_r      <= 1'b1;
      rx_byte_ready_o <= 1'b0;
      rx_last_r       <= host_event_i[`SDHDP_EV_RX_LAST];
    end else if (rd_data || rd_data_byte) begin
      rx_valid_r      <= 1'b0;
      rx_byte_ready_o <= 1'b1;
    end
  end

  // A word write is split into four bytes, least significant first for little
  // endian and most significant first for big endian; the bus never stalls, and a
  // new data window write during the split replaces the bytes not yet pushed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_word_r       <= 32'h00000000;
      tx_bytes_left_r <= 2'h0;
      tx_full_r       <= 1'b0;
      tx_push_r       <= 1'b0;
      tx_push_data_r  <= 8'h00;
    end else begin
      tx_push_r <= 1'b0;
      if (wr_data) begin
        tx_word_r       <= (endian_r == SDHDP_LITTLE) ? wb_dat_i :
                           {wb_dat_i[7:0], wb_dat_i[15:8], wb_dat_i[23:16], wb_dat_i[31:24]};
        tx_bytes_left_r <= 2'h3;
        tx_full_r       <= 1'b1;
      end else if (wr_data_byte) begin
        tx_word_r       <= (endian_r == SDHDP_LITTLE) ? {24'h000000, wb_dat_i[7:0]} :
                           {24'h000000, wb_dat_i[31:24]};
        tx_bytes_left_r <= 2'h0;
        tx_full_r       <= 1'b1;
      end else if (tx_full_r && tx_ready && !tx_push_r) begin
        tx_push_r      <= 1'b1;
        tx_push_data_r <= tx_word_r[7:0];
        tx_word_r      <= {8'h00, tx_word_r[31:8]};
        if (tx_bytes_left_r == 2'h0) begin
          tx_full_r <= 1'b0;
        end else begin
          tx_bytes_left_r <= tx_bytes_left_r - 2'h1;
        end
      end
    end
  end

  sdhdp_tx_fifo #(
    .DEPTH (FIFO_BYTES)
  ) u_tx_fifo (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_i       (tx_push_r),
    .wr_data_i  (tx_push_data_r),
    .wr_ready_o (tx_ready),
    .rd_i       (tx_byte_take_i),
    .rd_data_o  (tx_head),
    .rd_valid_o (tx_head_valid),
    .count_o    (tx_count),
    .half_o     (tx_half),
    .empty_o    (tx_empty)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_byte_o         <= 8'h00;
      tx_byte_valid_o   <= 1'b0;
      fifo_byte_count_r <= 7'h00;
    end else begin
      tx_byte_o         <= tx_head;
      tx_byte_valid_o   <= tx_head_valid;
      fifo_byte_count_r <= tx_count;
    end
  end
  assign fifo_byte_count_o = fifo_byte_count_r;

  // ----------------------------------------------------------------------
  // Interrupt enables and event flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_event_irq_enable_r <= `SDHDP_IRQEN_RST;
    end else if (req && wb_we_i && wb_adr_i == `SDHDP_IRQEN_OFS && wb_sel_i[0]) begin
      host_event_irq_enable_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) begin
        host_event_irq_enable_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        host_event_irq_enable_r[17:16] <= wb_dat_i[17:16];
      end
    end else if (req && wb_we_i && wb_adr_i == `SDHDP_IRQEN_OFS) begin
      if (wb_sel_i[1]) begin
        host_event_irq_enable_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        host_event_irq_enable_r[17:16] <= wb_dat_i[17:16];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_clear_r <= 18'h00000;
    end else if (req && wb_we_i && wb_adr_i == `SDHDP_FLAGS_OFS) begin
      flag_clear_r <= wb_dat_i[17:0];
    end else begin
      flag_clear_r <= 18'h00000;
    end
  end

  // Transmit FIFO levels and receive final data come from local state; the rest come from the host core.
  always_comb begin
    raw_events = host_event_i;
    raw_events[`SDHDP_EV_TX_HALF]  = tx_half;
    raw_events[`SDHDP_EV_TX_EMPTY] = tx_empty;
    raw_events[`SDHDP_EV_RX_LAST]  = rx_valid_r && rx_last_r;
  end

  sdhdp_event_flags #(
    .W (`SDHDP_IRQEN_W)
  ) u_flags (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .event_i      (raw_events),
    .latch_mask_i (`SDHDP_LATCH_MASK),
    .clear_i      (flag_clear_r),
    .flags_o      (flags)
  );

  // Each enable bit gates the event of the same position.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags & host_event_irq_enable_r);
    end
  end
  assign irq_o = irq_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_enabled_flag;
    |(flags & host_event_irq_enable_r);
  endsequence

  a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enabled_flag |=> irq_o)
    else $error("irq not raised");
  a_irq_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|(flags & host_event_irq_enable_r)) |=> !irq_o)
    else $error("irq not dropped");
  a_rsp_crc_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags == 18'h20000 && !host_event_irq_enable_r[17]) |=> !irq_o)
    else $error("disabled event raised irq");
  a_enable_reset: assert property (@(posedge clk_i)
    rst_i |=> (host_event_irq_enable_r == 18'h00000))
    else $error("enables not cleared by reset");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_word_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_data |=> (card_data_window_r == $past(wb_dat_i)))
    else $error("data window not written");
  a_le_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_data_byte && endian_r == SDHDP_LITTLE) |=>
      (card_data_window_r == {24'h000000, $past(wb_dat_i[7:0])}))
    else $error("little endian byte write wrong");
  a_tx_half: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[`SDHDP_EV_TX_HALF] == (tx_count <= 7'h20))
    else $error("half flag wrong level");
endmodule

// ===== bench/sdhdp_card_model.sv
// Card-side model that drains the transmit byte stream and feeds received bytes.
`timescale 1ns/1ps
module sdhdp_card_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       take_en_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_byte_valid_i,
  output logic            tx_byte_take_o,
  input  wire logic       rx_byte_ready_i,
  output logic [7:0]      rx_byte_o,
  output logic            rx_byte_valid_o
);
  logic [7:0] got[$];
  logic [7:0] rx_q[$];
  logic [1:0] gap_r;

  initial begin
    tx_byte_take_o = 1'b0;
    rx_byte_valid_o = 1'b0;
    rx_byte_o = 8'h3c;
  end

  task automatic push_rx(input logic [7:0] b);
    rx_q.push_back(b);
  endtask

  // Pops are spaced because the head only shows one cycle after each pop.
  always @(posedge clk_i) begin
    tx_byte_take_o <= 1'b0;
    if (rst_i) begin
      gap_r <= 2'h0;
    end else if (gap_r != 2'h0) begin
      gap_r <= gap_r - 2'h1;
    end else if (take_en_i && tx_byte_valid_i) begin
      tx_byte_take_o <= 1'b1;
      gap_r <= 2'h3;
      got.push_back(tx_byte_i);
    end
  end

  // Between bytes the line shows the inverse of the last value, never a stale copy.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_byte_valid_o <= 1'b0;
    end else if (rx_byte_valid_o && rx_byte_ready_i) begin
      void'(rx_q.pop_front());
      rx_byte_valid_o <= 1'b0;
      rx_byte_o <= ~rx_byte_o;
    end else if (!rx_byte_valid_o && rx_q.size() != 0) begin
      rx_byte_valid_o <= 1'b1;
      rx_byte_o <= rx_q[0];
    end
  end
endmodule

// ===== bench/sdhdp_top_tb.sv
// Self-checking bench for the card data window, interrupt enables and request line.
`timescale 1ns/1ps
`include "sdhdp_defs.svh"
module sdhdp_top_tb;
  import sdhdp_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [31:0] DAT = `SDHDP_DATA_OFS;
  localparam logic [31:0] IEN = `SDHDP_IRQEN_OFS;
  logic          clk_i, rst_i, cyc, stb, we, ack, rdy, take, txv, rxv, irq, ten;
  logic [31:0]   adr, wdat, rdat;
  logic [3:0]    sel;
  logic [17:0]   ev;
  logic [7:0]    txb, rxb;
  logic [6:0]    cnt;
  sdhdp_endian_t endn;
  int            errors, num_checks, cycles;

  sdhdp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .endian_i(endn), .host_event_i(ev), .rx_byte_i(rxb),
    .rx_byte_valid_i(rxv), .rx_byte_ready_o(rdy), .tx_byte_take_i(take),
    .tx_byte_o(txb), .tx_byte_valid_o(txv), .fifo_byte_count_o(cnt), .irq_o(irq));
  sdhdp_card_model card (.clk_i(clk_i), .rst_i(rst_i), .take_en_i(ten),
    .tx_byte_i(txb), .tx_byte_valid_i(txv), .tx_byte_take_o(take),
    .rx_byte_ready_i(rdy), .rx_byte_o(rxb), .rx_byte_valid_o(rxv));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic ci(input string w, input logic e);
    chk(w, {31'h0, e}, {31'h0, irq});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Reads sample just after the edge, so they see the values the slave held at it.
  task automatic bus(input logic w, input logic [31:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    chk("bus ack latency", 32'h2, n);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, s, d, q);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 4'hf, 32'h0, q);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    rd(DAT, d);
    chk("window reset", 32'h0, d);
    rd(IEN, d);
    chk("enable reset", 32'h0, d);
    chk("count reset", 32'h0, {25'h0, cnt});
    ci("irq reset", 1'b0);
    wr(IEN, 4'hf, 32'hffffffff);
    rd(IEN, d);
    chk("enable all", 32'h0003ffff, d);
    wr(IEN, 4'hf, 32'h0002aaaa);
    rd(IEN, d);
    chk("enable pattern", 32'h0002aaaa, d);
    wr(IEN, 4'hf, 32'h0);
    wr(32'h5a000050, 4'hf, 32'hffffffff);
    rd(32'h5a000050, d);
    chk("unmapped read", 32'h0, d);
  endtask

  task automatic t_latch;
    for (int i = 17; i >= 5; i--) begin
      wr(IEN, 4'hf, 32'h0);
      ev <= 18'h1 << i;
      idle(1);
      ev <= 18'h0;
      idle(3);
      ci("irq masked", 1'b0);
      wr(IEN, 4'hf, 32'h1 << i);
      idle(3);
      ci("irq enabled", 1'b1);
      wr(`SDHDP_FLAGS_OFS, 4'hf, 32'h1 << i);
      idle(3);
      ci("irq cleared", 1'b0);
    end
  endtask

  task automatic t_level;
    for (int i = 0; i < 2; i++) begin
      wr(IEN, 4'hf, 32'h1 << i);
      ev <= 18'h1 << i;
      idle(3);
      ci("irq level", 1'b1);
      ev <= 18'h0;
      idle(3);
      ci("irq level gone", 1'b0);
    end
  endtask

  task automatic t_tx;
    wr(IEN, 4'hf, 32'h10);
    for (int k = 0; k < 16; k++) begin
      wr(DAT, 4'hf, 32'h03020100 + 32'h04040404 * k);
      idle(10);
      chk("byte count", 4 * (k + 1), {25'h0, cnt});
      ci("irq tx half", k < 8);
    end
    wr(IEN, 4'hf, 32'h8);
    idle(3);
    ci("irq tx not empty", 1'b0);
    ten <= 1'b1;
    for (int n = 0; n < 600 && card.got.size() < 64; n++) idle(1);
    idle(8);
    ten <= 1'b0;
    for (int j = 0; j < 64; j++) chk("tx byte", j, {24'h0, card.got[j]});
    chk("byte count empty", 32'h0, {25'h0, cnt});
    ci("irq tx empty", 1'b1);
    card.got.delete();
    wr(IEN, 4'hf, 32'h0);
  endtask

  task automatic t_endian;
    logic [7:0] e [6] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h5e, 8'h77};
    endn <= SDHDP_BIG;
    ten <= 1'b1;
    idle(2);
    wr(DAT, 4'hf, 32'ha1b2c3d4);
    idle(20);
    wr(`SDHDP_DATA_BE_BYTE_OFS, 4'h8, 32'h5e000000);
    idle(8);
    endn <= SDHDP_LITTLE;
    idle(2);
    wr(DAT, 4'h1, 32'h00000077);
    idle(12);
    for (int j = 0; j < 6; j++) chk("endian byte", {24'h0, e[j]}, {24'h0, card.got[j]});
    ten <= 1'b0;
    card.got.delete();
  endtask

  task automatic t_rx;
    logic [31:0] d;
    wr(DAT, 4'hf, 32'h0);
    card.push_rx(8'ha5);
    idle(10);
    chk("rx ready held", 32'h0, {31'h0, rdy});
    rd(DAT, d);
    chk("rx window", 32'h000000a5, d);
    chk("rx ready free", 32'h1, {31'h0, rdy});
  endtask

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, ten} = 4'h0;
    adr = 32'h0;
    sel = 4'h0;
    wdat = 32'h0;
    ev = 18'h0;
    endn = SDHDP_LITTLE;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_latch();
    t_level();
    t_tx();
    t_endian();
    t_rx();
    wrap_up();
  end
endmodule
